// ===== rtl/psc_regs.svh
// Constants for the program counter and stack control block.
// Assumes inclusion by bare name from the core.
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// Register indices with dedicated roles.
`define PSC_IDX_PC    4'h0
`define PSC_IDX_SP    4'h1
`define PSC_IDX_SW    4'h2

// Reset value of every register.
`define PSC_RESET_VAL 20'h00000

// Stack and counter steps in bytes.
`define PSC_STEP_WORD 20'h00002
`define PSC_STEP_LONG 20'h00004

// Top of the downward-growing vector table.
`define PSC_VEC_TOP   20'h0fffe

// Field positions.
`define PSC_PC_HI     19:16
`define PSC_LO16      15:0
`define PSC_LO8       7:0
`define PSC_SW_PCHI   15:12
`define PSC_SW_FLAGS  11:0

`endif

// ===== rtl/psc_pkg.sv
// Types shared by the program counter and stack control block.
// Assumes nothing of its surroundings.
package psc_pkg;

	typedef enum logic [3:0] {
		PSC_CMD_NOP        = 4'h0,
		PSC_CMD_ADVANCE    = 4'h1,
		PSC_CMD_SHORT_JUMP = 4'h2,
		PSC_CMD_LONG_JUMP  = 4'h3,
		PSC_CMD_SHORT_CALL = 4'h4,
		PSC_CMD_LONG_CALL  = 4'h5,
		PSC_CMD_SHORT_RET  = 4'h6,
		PSC_CMD_LONG_RET   = 4'h7,
		PSC_CMD_INT_ENTRY  = 4'h8,
		PSC_CMD_INT_EXIT   = 4'h9,
		PSC_CMD_REG_WRITE  = 4'ha
	} psc_cmd_t;

	typedef enum logic [1:0] {
		PSC_SIZE_BYTE  = 2'h0,
		PSC_SIZE_WORD  = 2'h1,
		PSC_SIZE_AWORD = 2'h2
	} psc_size_t;

	typedef enum logic [0:0] {
		PSC_ST_IDLE = 1'b0,
		PSC_ST_MEM  = 1'b1
	} psc_state_t;

endpackage : psc_pkg

// ===== rtl/psc_control.sv
// Program counter, stack pointer and sixteen-entry register file with stack sequencing.
// Assumes a synchronous memory port on the same clock that answers each request with memAck.
//
// Behaviour
// [RQ1] Sixteen registers; indices zero to three dedicated, four to fifteen general; the code dedicates only zero to two, three is general.
// [RQ2] Program counter advances by instruction length of two, four, six or eight bytes.
// [RQ3] Program counter bit zero always zero; fetches on word boundaries.
// [RQ4] Short jump and short call clear upper four counter bits.
// [RQ5] Long jump and long call load the full 20-bit target.
// [RQ6] Direct counter writes follow operand size; word writes clear upper four bits.
// [RQ7] Calls and interrupt entry push return address; short call saves bits 15:0.
// [RQ8] Long subroutine exit reloads bits 19:0 and adds four to stack pointer.
// [RQ9] Short subroutine exit reloads bits 15:0 and adds two to stack pointer.
// [RQ10] Stack pointer predecrements on push and postincrements on pop.
// [RQ11] Stack pointer bit zero always zero; software sets it into RAM.
// [RQ12] Interrupt entry pushes counter and status word carrying counter bits 19:16.
// [RQ13] Interrupt exit rebuilds the full 20-bit counter from the stacked words.
// [RQ14] Vectors lie downward from the top vector address and hold 16-bit handlers.
// [RQ15] Counter and stack pointer are ordinary operands of every register access.
// [RQ16] 20-bit address bus over 1MB without paging, 16-bit data bus.
// [RQ17] Register-only operations complete in a single cycle.
// [RQ18] Byte, word and 20-bit address-word operand sizes.
// [RQ19] Long call pushes the full return address as two words, four bytes.
`timescale 1ns/100ps
`default_nettype none
`include "psc_regs.svh"

module psc_control (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Command port.
	input  wire logic              cmdValid,
	input  wire psc_pkg::psc_cmd_t  cmd,
	input  wire logic [19:0]       cmdTarget,
	input  wire logic [1:0]        cmdLen,
	input  wire logic [3:0]        cmdIdx,
	input  wire psc_pkg::psc_size_t cmdSize,
	output logic                   busy,
	// Register read ports.
	input  wire logic [3:0]        rdIdxA,
	input  wire logic [3:0]        rdIdxB,
	output logic [19:0]            rdDataA,
	output logic [19:0]            rdDataB,
	// Dedicated register views.
	output logic [19:0]            programCounter,
	output logic [19:0]            stackPointer,
	output logic [15:0]            statusWord,
	// Stack memory port.
	output logic                   memReq,
	output logic                   memWe,
	output logic [19:0]            memAddr,
	output logic [15:0]            memWdata,
	input  wire logic [15:0]       memRdata,
	input  wire logic              memAck
);
	import psc_pkg::*;

	logic [19:0] regFile_q [16];
	psc_state_t  state_q;
	logic [1:0]  step_q;
	psc_cmd_t    op_q;
	logic [19:0] tgt_q;
	logic [15:0] lo_q;
	logic [19:0] spAtCmd_q;
	logic        busy_q;
	logic        memReq_q;
	logic        memWe_q;
	logic [19:0] memAddr_q;
	logic [15:0] memWdata_q;
	logic [19:0] rdDataA_q;
	logic [19:0] rdDataB_q;

	logic        accept;
	logic        memDone;
	logic        issue;
	logic        issueWe;
	logic [19:0] issueAddr;
	logic [15:0] issueData;
	logic        finish;
	logic        spDec;
	logic        spInc;
	logic        pcLd;
	logic [19:0] pcVal;
	logic        swLd;
	logic [15:0] swVal;
	logic        loLd;
	logic [19:0] pc;
	logic [19:0] sp;
	logic [19:0] vecAddr;

	assign pc      = regFile_q[`PSC_IDX_PC];
	assign sp      = regFile_q[`PSC_IDX_SP];
	assign accept  = cmdValid && (state_q == PSC_ST_IDLE);
	assign memDone = (state_q == PSC_ST_MEM) && memAck;
	assign vecAddr = `PSC_VEC_TOP - {13'h0000, tgt_q[5:0], 1'b0}; // [RQ14]

	// Sized register write: byte clears 19:8, word clears 19:16.
	function automatic logic [19:0] pscSized(input logic [19:0] d, input psc_size_t s,
		input logic [3:0] idx);
		logic [19:0] v;
		v = d;
		if (s == PSC_SIZE_BYTE) begin
			v = {12'h000, d[`PSC_LO8]}; // [RQ18]
		end else if (s == PSC_SIZE_WORD || idx == `PSC_IDX_SW) begin
			v = {4'h0, d[`PSC_LO16]}; // [RQ6]
		end
		if (idx == `PSC_IDX_PC || idx == `PSC_IDX_SP) begin
			v[0] = 1'b0; // [RQ3] [RQ11]
		end
		return v;
	endfunction : pscSized

	// Decides the next memory access and register effects of each step.
	always_comb begin
		issue     = 1'b0;
		issueWe   = 1'b0;
		issueAddr = sp;
		issueData = 16'h0000;
		finish    = 1'b0;
		spDec     = 1'b0;
		spInc     = 1'b0;
		pcLd      = 1'b0;
		pcVal     = pc;
		swLd      = 1'b0;
		swVal     = statusWord;
		loLd      = 1'b0;
		if (accept) begin
			case (cmd)
				PSC_CMD_ADVANCE: begin
					pcLd  = 1'b1;
					pcVal = pc + {17'h00000, cmdLen, 1'b0} + `PSC_STEP_WORD; // [RQ2]
				end
				PSC_CMD_SHORT_JUMP: begin
					pcLd  = 1'b1;
					pcVal = {4'h0, cmdTarget[15:1], 1'b0}; // [RQ4]
				end
				PSC_CMD_LONG_JUMP: begin
					pcLd  = 1'b1;
					pcVal = {cmdTarget[19:1], 1'b0}; // [RQ5]
				end
				PSC_CMD_SHORT_CALL, PSC_CMD_INT_ENTRY: begin
					issue     = 1'b1;
					issueWe   = 1'b1;
					issueAddr = sp - `PSC_STEP_WORD; // [RQ10]
					issueData = pc[`PSC_LO16]; // [RQ7]
					spDec     = 1'b1;
				end
				PSC_CMD_LONG_CALL: begin
					issue     = 1'b1;
					issueWe   = 1'b1;
					issueAddr = sp - `PSC_STEP_WORD;
					issueData = {12'h000, pc[`PSC_PC_HI]}; // [RQ19]
					spDec     = 1'b1;
				end
				PSC_CMD_SHORT_RET, PSC_CMD_LONG_RET, PSC_CMD_INT_EXIT: begin
					issue     = 1'b1;
					issueAddr = sp;
				end
				default: begin
				end
			endcase
		end else if (memDone) begin
			case (op_q)
				PSC_CMD_SHORT_CALL: begin
					finish = 1'b1;
					pcLd   = 1'b1;
					pcVal  = {4'h0, tgt_q[15:1], 1'b0}; // [RQ4]
				end
				PSC_CMD_LONG_CALL: begin
					if (step_q == 2'h0) begin
						issue     = 1'b1;
						issueWe   = 1'b1;
						issueAddr = sp - `PSC_STEP_WORD;
						issueData = pc[`PSC_LO16]; // [RQ19]
						spDec     = 1'b1;
					end else begin
						finish = 1'b1;
						pcLd   = 1'b1;
						pcVal  = {tgt_q[19:1], 1'b0}; // [RQ5]
					end
				end
				PSC_CMD_INT_ENTRY: begin
					if (step_q == 2'h0) begin
						issue     = 1'b1;
						issueWe   = 1'b1;
						issueAddr = sp - `PSC_STEP_WORD;
						issueData = {pc[`PSC_PC_HI], statusWord[`PSC_SW_FLAGS]}; // [RQ12]
						spDec     = 1'b1;
					end else if (step_q == 2'h1) begin
						issue     = 1'b1;
						issueAddr = vecAddr; // [RQ14]
					end else begin
						finish = 1'b1;
						pcLd   = 1'b1;
						pcVal  = {4'h0, memRdata[15:1], 1'b0}; // [RQ14]
					end
				end
				PSC_CMD_SHORT_RET: begin
					finish = 1'b1;
					spInc  = 1'b1;
					pcLd   = 1'b1;
					pcVal  = {4'h0, memRdata[15:1], 1'b0}; // [RQ9]
				end
				PSC_CMD_LONG_RET, PSC_CMD_INT_EXIT: begin
					spInc = 1'b1; // [RQ10]
					if (step_q == 2'h0) begin
						issue     = 1'b1;
						issueAddr = sp + `PSC_STEP_WORD;
						loLd      = 1'b1;
						if (op_q == PSC_CMD_INT_EXIT) begin
							swLd  = 1'b1;
							swVal = memRdata;
						end
					end else begin
						finish = 1'b1;
						pcLd   = 1'b1;
						if (op_q == PSC_CMD_LONG_RET) begin
							pcVal = {memRdata[3:0], lo_q[15:1], 1'b0}; // [RQ8]
						end else begin
							pcVal = {lo_q[`PSC_SW_PCHI], memRdata[15:1], 1'b0}; // [RQ13]
						end
					end
				end
				default: begin
					finish = 1'b1;
				end
			endcase
		end
	end

	// Sequencer state and the registered memory request.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= PSC_ST_IDLE;
			step_q     <= 2'h0;
			op_q       <= PSC_CMD_NOP;
			tgt_q      <= `PSC_RESET_VAL;
			lo_q       <= 16'h0000;
			spAtCmd_q  <= `PSC_RESET_VAL;
			busy_q     <= 1'b0;
			memReq_q   <= 1'b0;
			memWe_q    <= 1'b0;
			memAddr_q  <= `PSC_RESET_VAL;
			memWdata_q <= 16'h0000;
		end else begin
			if (accept) begin
				op_q      <= cmd;
				tgt_q     <= cmdTarget;
				spAtCmd_q <= sp;
				step_q    <= 2'h0;
			end else if (memDone && issue) begin
				step_q <= step_q + 2'h1;
			end
			if (loLd) begin
				lo_q <= memRdata;
			end
			if (issue) begin
				state_q    <= PSC_ST_MEM;
				busy_q     <= 1'b1;
				memReq_q   <= 1'b1;
				memWe_q    <= issueWe;
				memAddr_q  <= issueAddr; // [RQ16]
				memWdata_q <= issueData;
			end else if (finish) begin
				state_q  <= PSC_ST_IDLE;
				busy_q   <= 1'b0;
				memReq_q <= 1'b0;
				memWe_q  <= 1'b0;
			end
		end
	end

	// Register file; register-only commands and the first stack pointer decrement of a push land on the accepting edge, later stack updates on memAck edges.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				regFile_q[i] <= `PSC_RESET_VAL; // [RQ1]
			end
		end else begin
			if (accept && cmd == PSC_CMD_REG_WRITE) begin
				regFile_q[cmdIdx] <= pscSized(cmdTarget, cmdSize, cmdIdx); // [RQ15] [RQ17]
			end
			if (pcLd) begin
				regFile_q[`PSC_IDX_PC] <= pcVal;
			end
			if (spDec) begin
				regFile_q[`PSC_IDX_SP] <= sp - `PSC_STEP_WORD; // [RQ10]
			end else if (spInc) begin
				regFile_q[`PSC_IDX_SP] <= sp + `PSC_STEP_WORD; // [RQ10]
			end
			if (swLd) begin
				regFile_q[`PSC_IDX_SW] <= {4'h0, swVal};
			end
		end
	end

	// Registered read ports.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdDataA_q <= `PSC_RESET_VAL;
			rdDataB_q <= `PSC_RESET_VAL;
		end else begin
			rdDataA_q <= regFile_q[rdIdxA]; // [RQ15]
			rdDataB_q <= regFile_q[rdIdxB];
		end
	end

	assign busy           = busy_q;
	assign rdDataA        = rdDataA_q;
	assign rdDataB        = rdDataB_q;
	assign programCounter = regFile_q[`PSC_IDX_PC];
	assign stackPointer   = regFile_q[`PSC_IDX_SP];
	assign statusWord     = regFile_q[`PSC_IDX_SW][`PSC_LO16];
	assign memReq         = memReq_q;
	assign memWe          = memWe_q;
	assign memAddr        = memAddr_q;
	assign memWdata       = memWdata_q;

	a_pc_even: // [RQ3]
	assert property (@(posedge clk) disable iff (!rst_n) !programCounter[0])
		else $error("program counter odd");

	a_sp_even: // [RQ11]
	assert property (@(posedge clk) disable iff (!rst_n) !stackPointer[0])
		else $error("stack pointer odd");

	a_advance_len: // [RQ2]
	assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmd == PSC_CMD_ADVANCE |=> programCounter ==
		$past(programCounter) + {17'h00000, $past(cmdLen), 1'b0} + 20'h00002)
		else $error("advance length wrong");

	a_short_jump_hi: // [RQ4]
	assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmd == PSC_CMD_SHORT_JUMP |=> programCounter[19:16] == 4'h0
		&& programCounter[15:1] == $past(cmdTarget[15:1]))
		else $error("short jump upper bits");

	a_long_jump_full: // [RQ5]
	assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmd == PSC_CMD_LONG_JUMP |=> programCounter[19:1] == $past(cmdTarget[19:1]))
		else $error("long jump target");

	a_word_write_pc: // [RQ6]
	assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmd == PSC_CMD_REG_WRITE && cmdIdx == 4'h0 && cmdSize == PSC_SIZE_WORD
		|=> programCounter[19:16] == 4'h0 && !busy)
		else $error("word write kept upper bits");

	a_short_call_push: // [RQ7]
	assert property (@(posedge clk) disable iff (!rst_n)
		accept && cmd == PSC_CMD_SHORT_CALL |=> memReq && memWe
		&& memWdata == $past(programCounter[15:0])
		&& memAddr == $past(stackPointer) - 20'h00002)
		else $error("short call push");

	a_long_ret_sp: // [RQ8]
	assert property (@(posedge clk) disable iff (!rst_n)
		finish && op_q == PSC_CMD_LONG_RET |=> stackPointer == spAtCmd_q + 20'h00004 && !busy)
		else $error("long exit stack step");

	a_short_ret_sp: // [RQ9]
	assert property (@(posedge clk) disable iff (!rst_n)
		finish && op_q == PSC_CMD_SHORT_RET |=> stackPointer == spAtCmd_q + 20'h00002
		&& programCounter[19:16] == 4'h0)
		else $error("short exit stack step");

	a_long_call_sp: // [RQ19]
	assert property (@(posedge clk) disable iff (!rst_n)
		finish && op_q == PSC_CMD_LONG_CALL |=> stackPointer == spAtCmd_q - 20'h00004)
		else $error("long call stack use");

	a_int_entry_sw: // [RQ12]
	assert property (@(posedge clk) disable iff (!rst_n)
		memDone && op_q == PSC_CMD_INT_ENTRY && step_q == 2'h0
		|=> memWe && memWdata[15:12] == programCounter[19:16])
		else $error("status word lacks counter bits");

	a_int_vector: // [RQ14]
	assert property (@(posedge clk) disable iff (!rst_n)
		memDone && op_q == PSC_CMD_INT_ENTRY && step_q == 2'h1
		|=> !memWe && memAddr == 20'h0fffe - {13'h0000, tgt_q[5:0], 1'b0})
		else $error("vector address wrong");

	a_int_exit_pc: // [RQ13]
	assert property (@(posedge clk) disable iff (!rst_n)
		finish && op_q == PSC_CMD_INT_EXIT |=> programCounter[19:16] == $past(lo_q[15:12]))
		else $error("interrupt exit counter");

endmodule : psc_control
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the program counter and stack control block.
// Assumes the bench answers every stack request from a memory of its own spanning all 1048576 words.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import psc_pkg::*;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cmdValid = 1'b0;
	psc_cmd_t    cmd = PSC_CMD_NOP;
	logic [19:0] cmdTarget = 20'h00000;
	logic [1:0]  cmdLen = 2'h0;
	logic [3:0]  cmdIdx = 4'h0;
	psc_size_t   cmdSize = PSC_SIZE_WORD;
	logic [3:0]  rdIdxA = 4'h0;
	logic [3:0]  rdIdxB = 4'h0;
	logic [15:0] memRdata = 16'h0000;
	logic        memAck = 1'b0;
	logic        busy, memReq, memWe;
	logic [19:0] rdDataA, rdDataB, programCounter, stackPointer, memAddr, expPc;
	logic [15:0] statusWord, memWdata;
	logic [15:0] mem [1048576];
	int          n_mismatch = 0;
	int          checks = 0;
	int          cyc = 0;
	int          ackDelay = 0;
	int          waitCnt = 0;

	always #12.5 clk = ~clk;

	psc_control u_dut (
		.clk(clk), .rst_n(rst_n),
		.cmdValid(cmdValid), .cmd(cmd), .cmdTarget(cmdTarget), .cmdLen(cmdLen),
		.cmdIdx(cmdIdx), .cmdSize(cmdSize), .busy(busy),
		.rdIdxA(rdIdxA), .rdIdxB(rdIdxB), .rdDataA(rdDataA), .rdDataB(rdDataB),
		.programCounter(programCounter), .stackPointer(stackPointer),
		.statusWord(statusWord),
		.memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata), .memAck(memAck)
	);

	// Memory answers after ackDelay cycles; read data is scrambled except on a read answer.
	always @(posedge clk) begin
		#1;
		if (memReq === 1'b1 && waitCnt >= ackDelay) begin
			waitCnt = 0;
			memAck = 1'b1;
			if (memWe === 1'b1) begin
				mem[memAddr] = memWdata;
				memRdata = ~memRdata;
			end else begin
				memRdata = mem[memAddr];
			end
		end else begin
			waitCnt = (memReq === 1'b1) ? waitCnt + 1 : 0;
			memAck = 1'b0;
			memRdata = ~memRdata;
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Presents one command for one edge, then lets the next edge land.
	task automatic issue(input psc_cmd_t c, input logic [19:0] t);
		cmdValid = 1'b1;
		cmd = c;
		cmdTarget = t;
		@(posedge clk);
		#1;
		cmdValid = 1'b0;
		@(posedge clk);
		#1;
	endtask : issue

	task automatic waitIdle();
		for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		check({19'h0, busy}, 20'h00000);
	endtask : waitIdle

	task automatic wr(input logic [3:0] i, input psc_size_t s, input logic [19:0] v);
		cmdIdx = i;
		cmdSize = s;
		issue(PSC_CMD_REG_WRITE, v);
	endtask : wr

	task automatic rd(input logic [3:0] i, input logic [19:0] e);
		rdIdxA = i;
		rdIdxB = i;
		@(posedge clk);
		#1;
		check(rdDataA, e);
		check(rdDataB, e);
	endtask : rd

	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		check(programCounter, 20'h00000);
		wr(4'h1, PSC_SIZE_AWORD, 20'h23457);
		check(stackPointer, 20'h23456);
		wr(4'h5, PSC_SIZE_BYTE, 20'habcde);
		rd(4'h5, 20'h000de);
		wr(4'h6, PSC_SIZE_WORD, 20'habcde);
		rd(4'h6, 20'h0bcde);
		wr(4'hf, PSC_SIZE_AWORD, 20'habcde);
		rd(4'hf, 20'habcde);
		wr(4'h0, PSC_SIZE_WORD, 20'h51235);
		check(programCounter, 20'h01234);
		wr(4'h0, PSC_SIZE_AWORD, 20'h51235);
		rd(4'h0, 20'h51234);
		rd(4'h1, 20'h23456);
		expPc = 20'h51234;
		for (int n = 0; n < 4; n++) begin
			cmdLen = n[1:0];
			issue(PSC_CMD_ADVANCE, 20'h00000);
			expPc = expPc + 20'(2 * (n + 1));
			check(programCounter, expPc);
		end
		issue(PSC_CMD_NOP, 20'h12345);
		check(programCounter, expPc);
		issue(PSC_CMD_SHORT_JUMP, 20'hf8883);
		check(programCounter, 20'h08882);
		issue(PSC_CMD_LONG_JUMP, 20'habcd7);
		check(programCounter, 20'habcd6);
		// A slow memory keeps busy up, so the jump behind the call must be dropped.
		ackDelay = 4;
		issue(PSC_CMD_SHORT_CALL, 20'h10100);
		issue(PSC_CMD_LONG_JUMP, 20'h44444);
		waitIdle();
		check(programCounter, 20'h00100);
		check(stackPointer, 20'h23454);
		check({4'h0, mem[20'h23454]}, 20'h0bcd6);
		issue(PSC_CMD_LONG_JUMP, 20'h71110);
		ackDelay = 0;
		issue(PSC_CMD_LONG_CALL, 20'h92222);
		waitIdle();
		check(programCounter, 20'h92222);
		check(stackPointer, 20'h23450);
		check({4'h0, mem[20'h23452]}, 20'h00007);
		check({4'h0, mem[20'h23450]}, 20'h01110);
		issue(PSC_CMD_LONG_RET, 20'h00000);
		waitIdle();
		check(programCounter, 20'h71110);
		check(stackPointer, 20'h23454);
		issue(PSC_CMD_SHORT_RET, 20'h00000);
		waitIdle();
		check(programCounter, 20'h0bcd6);
		check(stackPointer, 20'h23456);
		wr(4'h2, PSC_SIZE_WORD, 20'h00abc);
		issue(PSC_CMD_LONG_JUMP, 20'h34566);
		mem[20'h0fff4] = 16'h4440;
		ackDelay = 2;
		issue(PSC_CMD_INT_ENTRY, 20'h00005);
		waitIdle();
		check(programCounter, 20'h04440);
		check(stackPointer, 20'h23452);
		check({4'h0, mem[20'h23454]}, 20'h04566);
		check({4'h0, mem[20'h23452]}, 20'h03abc);
		issue(PSC_CMD_INT_EXIT, 20'h00000);
		waitIdle();
		check(programCounter, 20'h34566);
		check(stackPointer, 20'h23456);
		check({4'h0, statusWord}, 20'h03abc);
		test_done();
	end
endmodule : tb
`default_nettype wire
